// File: shared/acs_regs.vh
/*
  constants for the converter conversion sequencer: register offsets,
  field positions, reset values and timing counts.
  assumes inclusion by the sequencer design file only.
*/
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ACS_ADDR_CTRL      3'h0
`define ACS_ADDR_SEL       3'h1
`define ACS_ADDR_RES_LO    3'h2
`define ACS_ADDR_RES_HI    3'h3
`define ACS_ADDR_ACTIVE    3'h4

// ----------------------------------------------------------------
// control/status and selection fields, reset values
// ----------------------------------------------------------------
`define ACS_CTRL_EN        7
`define ACS_CTRL_START     6
`define ACS_CTRL_AUTO      5
`define ACS_CTRL_DONE      4
`define ACS_CTRL_IE        3
`define ACS_CTRL_DIV_HI    2
`define ACS_CTRL_DIV_LO    0
`define ACS_SEL_REF_HI     7
`define ACS_SEL_REF_LO     6
`define ACS_SEL_CH_HI      3
`define ACS_SEL_CH_LO      0
`define ACS_CTRL_RESET     8'h00
`define ACS_SEL_RESET      8'h00

// ----------------------------------------------------------------
// timing: clock rates in Hz, sync stage count, conversion and sample counts in half converter clock periods
// ----------------------------------------------------------------
`define ACS_CPU_HZ         10000000
`define ACS_MIN_CPU_HZ     100000
`define ACS_NORM_HALVES    6'd26
`define ACS_FIRST_HALVES   6'd50
`define ACS_AUTO_HALVES    6'd27
`define ACS_NORM_SH_HALVES 6'd3
`define ACS_FIRST_SH_HALVES 6'd27
`define ACS_AUTO_SH_HALVES 6'd4
`define ACS_SYNC_STAGES    3

`endif

// File: rtl/acs_sequencer.v
/*
  conversion sequencer: prescaler, start modes, selection buffering,
  sleep start, completion flag and interrupt request.
  assumes an external successive-approximation core returning a 10-bit
  result at completion; register port and sleep inputs on mclk.
*/
`timescale 1ns/1ps
`include "acs_regs.vh"
`default_nettype none

module acs_sequencer
(
  input  wire       mclk,
  input  wire       rst_n,
  input  wire [2:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  input  wire       trigger_in,
  input  wire       free_run_sel,
  input  wire       sleep_quiet,
  input  wire [9:0] sar_result,
  output reg        sample_hold,
  output reg        conv_active,
  output reg  [3:0] input_channel_select,
  output reg  [1:0] reference_select,
  output wire       done_irq
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg       converter_enable_q;
  reg       conversion_start_flag_q;
  reg       auto_trigger_enable_q;
  reg       conversion_done_flag_q;
  reg       irq_enable_q;
  reg [2:0] clock_divider_select_q;
  reg [7:0] sel_temp_q;
  reg [9:0] result_q;
  reg       first_q;
  reg [6:0] presc_q;
  reg       start_pend_q;
  reg       busy_q;
  reg [5:0] half_q;
  reg [5:0] len_q;
  reg [5:0] sh_q;
  reg       auto_conv_q;
  reg [2:0] trig_sync_q;
  reg       sleep_q;

  // ratio code to prescaler tap (power of two)
  function [2:0] div_tap;
    input [2:0] code;
    begin
      div_tap = (code == 3'h0) ? 3'h0 : (code - 3'h1);
    end
  endfunction

  // ----------------------------------------------------------------
  // prescaler and converter clock edges
  // ----------------------------------------------------------------
  wire [2:0] tap      = div_tap(clock_divider_select_q);
  wire [6:0] presc_nx = presc_q + 7'h01;
  wire       conv_clk = presc_q[tap];
  wire       half_edge = (presc_nx[tap] != conv_clk);
  wire       rise_edge = half_edge & ~conv_clk;
  wire       trig_rise = trig_sync_q[1] & ~trig_sync_q[2];
  wire       trig_go  = auto_trigger_enable_q & converter_enable_q &
                        ~free_run_sel & trig_rise &
                        ~busy_q;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      presc_q <= 7'h00;
    else if (!converter_enable_q || trig_go)
      presc_q <= 7'h00;
    else
      presc_q <= presc_nx;
  end

  // ----------------------------------------------------------------
  // trigger synchroniser
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      trig_sync_q <= 3'h0;
    else
      trig_sync_q <= {trig_sync_q[1:0], trigger_in};
  end

  // ----------------------------------------------------------------
  // sleep entry edge; other sleep modes leave the enable alone
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      sleep_q <= 1'b0;
    else
      sleep_q <= sleep_quiet;
  end

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  wire wr_ctrl = reg_wr && (reg_addr == `ACS_ADDR_CTRL);
  wire wr_sel  = reg_wr && (reg_addr == `ACS_ADDR_SEL);
  wire done_ev = busy_q && half_edge && (half_q == len_q - 6'd1);
  wire last_cy = busy_q && (half_q >= len_q - 6'd2);
  wire sleep_go = sleep_quiet & ~sleep_q & converter_enable_q & ~busy_q &
                  ~auto_trigger_enable_q & irq_enable_q;
  wire clr_en  = wr_ctrl && !reg_wdata[`ACS_CTRL_EN];

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      converter_enable_q      <= 1'b0;
      auto_trigger_enable_q   <= 1'b0;
      irq_enable_q            <= 1'b0;
      clock_divider_select_q  <= 3'h0;
      sel_temp_q              <= `ACS_SEL_RESET;
    end
    else
    begin
      if (wr_ctrl)
      begin
        converter_enable_q     <= reg_wdata[`ACS_CTRL_EN];
        auto_trigger_enable_q  <= reg_wdata[`ACS_CTRL_AUTO];
        irq_enable_q           <= reg_wdata[`ACS_CTRL_IE];
        clock_divider_select_q <= reg_wdata[`ACS_CTRL_DIV_HI:`ACS_CTRL_DIV_LO];
      end
      if (wr_sel)
        sel_temp_q <= reg_wdata;
    end
  end

  // ----------------------------------------------------------------
  // start flag and pending software start
  // ----------------------------------------------------------------
  wire sw_start = wr_ctrl && reg_wdata[`ACS_CTRL_START] &&
                  reg_wdata[`ACS_CTRL_EN];
  wire restart  = done_ev && free_run_sel && auto_trigger_enable_q;
  wire done_clr = wr_ctrl && reg_wdata[`ACS_CTRL_DONE];

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      conversion_start_flag_q <= 1'b0;
      start_pend_q            <= 1'b0;
    end
    else
    begin
      if (clr_en)
      begin
        conversion_start_flag_q <= 1'b0;
        start_pend_q            <= 1'b0;
      end
      else if (sw_start || sleep_go)
      begin
        conversion_start_flag_q <= 1'b1;
        start_pend_q            <= !busy_q;
      end
      else if (trig_go)
        conversion_start_flag_q <= 1'b1;
      else if (done_ev && !restart)
        conversion_start_flag_q <= 1'b0;
      if (!clr_en && !(sw_start || sleep_go) && rise_edge)
        start_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // first-conversion marker, set again while the converter is off
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      first_q <= 1'b1;
    else if (!converter_enable_q && !(wr_ctrl && reg_wdata[`ACS_CTRL_EN]))
      first_q <= 1'b1;
    else if (busy_q)
      first_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // done flag: completion wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      conversion_done_flag_q <= 1'b0;
    else if (done_ev)
      conversion_done_flag_q <= 1'b1;
    else if (done_clr)
      conversion_done_flag_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  wire begin_sw = start_pend_q && rise_edge && converter_enable_q;

  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy_q      <= 1'b0;
      half_q      <= 6'd0;
      len_q       <= `ACS_NORM_HALVES;
      sh_q        <= `ACS_NORM_SH_HALVES;
      auto_conv_q <= 1'b0;
      result_q    <= 10'h000;
      sample_hold <= 1'b0;
    end
    else
    begin
      sample_hold <= 1'b0;
      if (!converter_enable_q)
        busy_q <= 1'b0;
      else if (trig_go)
      begin
        busy_q      <= 1'b1;
        half_q      <= 6'd0;
        auto_conv_q <= 1'b1;
        len_q       <= first_q ? `ACS_FIRST_HALVES : `ACS_AUTO_HALVES;
        sh_q        <= first_q ? `ACS_FIRST_SH_HALVES : `ACS_AUTO_SH_HALVES;
      end
      else if (begin_sw || (restart && half_edge))
      begin
        busy_q      <= 1'b1;
        half_q      <= 6'd0;
        auto_conv_q <= 1'b0;
        len_q       <= first_q ? `ACS_FIRST_HALVES : `ACS_NORM_HALVES;
        sh_q        <= first_q ? `ACS_FIRST_SH_HALVES : `ACS_NORM_SH_HALVES;
        if (done_ev)
          result_q  <= sar_result;
      end
      else if (busy_q && half_edge)
      begin
        half_q <= half_q + 6'd1;
        if (half_q + 6'd1 == sh_q)
          sample_hold <= 1'b1;
        if (done_ev)
        begin
          busy_q   <= 1'b0;
          result_q <= sar_result;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // active selection follows temp register except while locked
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      input_channel_select <= 4'h0;
      reference_select     <= 2'h0;
      conv_active          <= 1'b0;
    end
    else
    begin
      conv_active <= busy_q;
      if (!busy_q || last_cy)
      begin
        input_channel_select <= sel_temp_q[`ACS_SEL_CH_HI:`ACS_SEL_CH_LO];
        reference_select     <= sel_temp_q[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO];
      end
    end
  end

  assign done_irq = conversion_done_flag_q & irq_enable_q;

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  reg [7:0] rdata_d;

  always @*
  begin
    case (reg_addr)
      `ACS_ADDR_CTRL:   rdata_d = {converter_enable_q,
                                   conversion_start_flag_q | busy_q,
                                   auto_trigger_enable_q,
                                   conversion_done_flag_q,
                                   irq_enable_q,
                                   clock_divider_select_q};
      `ACS_ADDR_SEL:    rdata_d = {sel_temp_q[7:6], 2'h0, sel_temp_q[3:0]};
      `ACS_ADDR_RES_LO: rdata_d = result_q[7:0];
      `ACS_ADDR_RES_HI: rdata_d = {6'h00, result_q[9:8]};
      `ACS_ADDR_ACTIVE: rdata_d = {reference_select, 1'b0, busy_q,
                                   input_channel_select};
      default:          rdata_d = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // read port, data stands one cycle only
  // ----------------------------------------------------------------
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rdata_d;
    else
      reg_rdata <= 8'h00;
  end

endmodule

`default_nettype wire

// File: verification/acs_seq_chk_assertions.sv
/*
  port checker for the conversion sequencer.
  assumes a bind onto acs_sequencer, one mclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_seq_chk
(
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       sample_hold,
  input wire logic       conv_active,
  input wire logic [3:0] input_channel_select,
  input wire logic [1:0] reference_select,
  input wire logic       done_irq
);
  logic en_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // enable shadow and step sequences
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      en_q <= 1'b0;
    else if (reg_wr && reg_addr == 3'h0)
      en_q <= reg_wdata[7];
  sequence s_sel_hold;
    $stable(input_channel_select) && $stable(reference_select);
  endsequence
  sequence s_off_wr;
    reg_wr && reg_addr == 3'h0 && !reg_wdata[7];
  endsequence
  sequence s_irq_off;
    reg_wr && reg_addr == 3'h0 && !reg_wdata[3];
  endsequence
  sequence s_go_wr;
    reg_wr && reg_addr == 3'h0 && reg_wdata[7:6] == 2'b11 &&
      reg_wdata[2:1] == 2'b00 && !conv_active;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  chk_sh_single: assert property (sample_hold |=> !sample_hold [*8])
    else $error("sample strobe not a lone pulse");
  chk_sel_frozen: assert property (sample_hold |-> s_sel_hold [*8])
    else $error("selection moved during conversion");
  chk_sh_busy: assert property (sample_hold |-> ##[0:2] conv_active)
    else $error("sample strobe without busy");
  chk_off_quiet: assert property (!en_q [*3] |-> !sample_hold && !conv_active)
    else $error("activity while disabled");
  chk_abort_busy: assert property (s_off_wr |-> ##[1:3] !conv_active)
    else $error("disable did not abort");
  chk_ie_clear: assert property (s_irq_off |=> !done_irq)
    else $error("request with enable cleared");
  chk_irq_hold: assert property (done_irq && !reg_wr |=> done_irq)
    else $error("done request dropped by itself");
  chk_start_sh: assert property (s_go_wr |-> ##[3:40] sample_hold)
    else $error("start write gave no sample");
endmodule
bind acs_sequencer acs_seq_chk u_chk
(
  .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .sample_hold(sample_hold), .conv_active(conv_active),
  .input_channel_select(input_channel_select),
  .reference_select(reference_select), .done_irq(done_irq)
);
`default_nettype wire

// File: verification/acs_sar_model.sv
/*
  analog core stand-in: new code at each sample instant.
  assumes sample_hold is a one-cycle pulse on mclk.
*/
`timescale 1ns/1ps
`default_nettype none
module acs_sar_model
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       sample_hold,
  output var  logic [9:0] sar_result
);
  // code held steady from sample to completion
  always_ff @(posedge mclk or negedge rst_n)
    if (!rst_n)
      sar_result <= 10'h2A5;
    else if (sample_hold)
      sar_result <= sar_result + 10'h15B;
endmodule
`default_nettype wire

// File: verification/tb_top.sv
/*
  self-checking bench for the conversion sequencer.
  assumes the checker bind and the analog core model.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic [2:0]  reg_addr = 3'h0;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        trigger_in = 1'b0;
  logic        free_run_sel = 1'b0;
  logic        sleep_quiet = 1'b0;
  logic        rd_q = 1'b0;
  logic [15:0] note;
  logic [7:0]  sel;
  logic [15:0] exp_q[$];
  wire  [7:0]  reg_rdata;
  wire  [9:0]  sar_result;
  wire  [3:0]  input_channel_select;
  wire  [1:0]  reference_select;
  wire         sample_hold, conv_active, done_irq;
  int          error_cnt = 0;
  int          checks_done = 0;
  int          t_sh, t_dn, k, h;
  always #50 mclk = ~mclk;
  acs_sequencer u_dut
  (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .trigger_in(trigger_in), .free_run_sel(free_run_sel),
    .sleep_quiet(sleep_quiet), .sar_result(sar_result),
    .sample_hold(sample_hold), .conv_active(conv_active),
    .input_channel_select(input_channel_select),
    .reference_select(reference_select), .done_irq(done_irq)
  );
  acs_sar_model u_sar
  (
    .mclk(mclk), .rst_n(rst_n), .sample_hold(sample_hold),
    .sar_result(sar_result)
  );
  // ----------------------------------------------------------------
  // bus tasks, waits and compares
  // ----------------------------------------------------------------
  task automatic fail(input string msg);
    error_cnt++;
    $display("wrong value at %0t: %s", $time, msg);
  endtask
  task automatic chk_rng(input int got, input int lo, input int hi);
    checks_done++;
    if (got < lo || got > hi)
      fail($sformatf("count %0d outside %0d..%0d", got, lo, hi));
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m,
                    input logic [7:0] e);
    exp_q.push_back({m, e});
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
  endtask
  task automatic wt(input bit w, input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge mclk);
      n++;
    end
    while ((w ? done_irq : sample_hold) !== 1'b1 && n < lim);
  endtask
  task automatic results;
    $display("errors %0d, checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // read data checked against the oldest note
  always @(posedge mclk)
  begin
    if (rd_q)
    begin
      note = exp_q.pop_front();
      checks_done++;
      if ((reg_rdata & note[15:8]) !== note[7:0])
        fail("register read");
    end
    rd_q <= reg_rd;
  end
  initial
  begin
    #(100 * 20000);
    error_cnt++;
    results();
  end
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    k = $urandom(32'h4628);
    sel = $urandom() & 8'hCF;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    rd(3'h0, 8'hFF, 8'h00);
    wr(3'h6, 8'hFF);
    rd(3'h6, 8'hFF, 8'h00);
    wr(3'h1, sel);
    rd(3'h4, 8'hCF, sel);
    wr(3'h0, 8'hC9);
    rd(3'h0, 8'h40, 8'h40);
    wr(3'h0, 8'h89);
    rd(3'h0, 8'h40, 8'h40);
    wr(3'h1, ~sel & 8'hCF);
    rd(3'h4, 8'hCF, sel);
    wt(1'b0, 100, t_sh);
    wt(1'b1, 100, t_dn);
    chk_rng(t_dn, 22, 24);
    rd(3'h0, 8'h50, 8'h10);
    rd(3'h2, 8'hFF, sar_result[7:0]);
    rd(3'h3, 8'hFF, {6'h00, sar_result[9:8]});
    rd(3'h4, 8'hCF, ~sel & 8'hCF);
    for (k = 0; k < 8; k++)
    begin
      h = (k < 2) ? 1 : (1 << (k - 1));
      wr(3'h0, {5'b11011, k[2:0]});
      wt(1'b0, 2000, t_sh);
      wt(1'b1, 2000, t_dn);
      chk_rng(t_sh, 3 * h, 5 * h + 2);
      chk_rng(t_dn, 23 * h - 1, 23 * h + 1);
    end
    wr(3'h0, 8'hBB);
    @(posedge mclk);
    trigger_in <= 1'b1;
    wt(1'b0, 100, t_sh);
    chk_rng(t_sh, 17, 23);
    @(posedge mclk);
    trigger_in <= 1'b0;
    repeat (8) @(posedge mclk);
    trigger_in <= 1'b1;
    wt(1'b1, 200, t_dn);
    chk_rng(t_dn, 83, 85);
    wr(3'h1, sel);
    wt(1'b0, 200, t_sh);
    chk_rng(t_sh, 200, 200);
    rd(3'h4, 8'hCF, sel);
    @(posedge mclk);
    trigger_in <= 1'b0;
    free_run_sel <= 1'b1;
    wr(3'h0, 8'hF9);
    wt(1'b0, 100, t_sh);
    wt(1'b0, 100, t_sh);
    chk_rng(t_sh, 25, 28);
    rd(3'h0, 8'h40, 8'h40);
    wr(3'h0, 8'h00);
    wt(1'b0, 100, t_sh);
    chk_rng(t_sh, 100, 100);
    rd(3'h0, 8'hC0, 8'h00);
    free_run_sel <= 1'b0;
    wr(3'h0, 8'h99);
    @(posedge mclk);
    sleep_quiet <= 1'b1;
    wt(1'b0, 100, t_sh);
    chk_rng(t_sh, 27, 33);
    @(posedge mclk);
    sleep_quiet <= 1'b0;
    wt(1'b1, 100, t_dn);
    chk_rng(t_dn, 21, 24);
    repeat (4) @(posedge mclk);
    results();
  end
endmodule
`default_nettype wire
